// ===== dslc_host_model.sv
`default_nettype none

module dslc_host_model (
   output logic sclk,
   output logic frame_n,
   output logic serial_in,
   input wire logic serial_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sclk = 1'b0;
      frame_n = 1'b1;
      serial_in = 1'b0;
   end

   // The clock runs at 8 MHz only inside a frame, inside both rate limits.
   task automatic send(input logic [23:0] w, output logic [23:0] r);
      // The odd start keeps the frame_n fall off a ref_clk edge when send starts on one, but every second sclk fall lands on one.
      #101 frame_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         #62.5 sclk = 1'b1;
         serial_in = w[i];
         #62.5 sclk = 1'b0;
         r[i] = serial_out;
      end
      #30 frame_n = 1'b1;
      // A released data line must not keep looking valid.
      serial_in = ~serial_in;
   endtask
endmodule

`default_nettype wire

// ===== dslc_monitor.sv
`default_nettype none

module dslc_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic frame_n,
   input wire logic serial_in,
   input wire logic load_output_n,
   input wire logic clear_code_n,
   input wire logic reset_n,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic [dslc_pkg::DAC_BITS-1:0] dac_code,
   input wire logic dac_update,
   input wire logic twos_comp
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] cnt_reg;
   logic [23:0] sh_reg;
   logic [3:0] age_reg;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // A private copy of the frame lets the checker predict the code.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 5'h00;
         sh_reg <= 24'h000000;
      end else if (frame_n) begin
         cnt_reg <= 5'h00;
      end else if ($fell(sclk)) begin
         cnt_reg <= cnt_reg + 5'h01;
         sh_reg <= {sh_reg[22:0], serial_in};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         age_reg <= 4'hF;
      end else if ($rose(sclk)) begin
         age_reg <= 4'h0;
      end else if (age_reg != 4'hF) begin
         age_reg <= age_reg + 4'h1;
      end
   end

   sequence s_dac_word_end;
      $rose(frame_n) && cnt_reg == 5'h18 && sh_reg[23] == 1'b0 &&
      sh_reg[22:20] == dslc_pkg::ADDR_DAC && !load_output_n &&
      clear_code_n && reset_n;
   endsequence

   sequence s_dac_loaded;
      dac_update && dac_code == (sh_reg[15:0] ^ {twos_comp, 15'h0000});
   endsequence

   a_reset_restores: assert property (!reset_n [*8] |-> ##1
      (dac_code == dslc_pkg::DAC_RST && !twos_comp))
      else $error("reset pin did not restore the code");
   a_clear_forces: assert property ((!clear_code_n && reset_n) [*6]
      |-> dac_update) else $error("clear did not load the output");
   a_code_steady: assert property ($changed(dac_code) |->
      (dac_update || $changed(twos_comp) || !reset_n))
      else $error("code changed without an update");
   a_load_defers: assert property (
      (load_output_n && clear_code_n && reset_n) [*8] |-> !dac_update)
      else $error("update while load is high");
   a_load_release: assert property (
      $fell(load_output_n) && clear_code_n && reset_n |-> ##[3:8] dac_update)
      else $error("load fall gave no update");
   a_frame_loads: assert property (
      s_dac_word_end |-> ##[4:10] s_dac_loaded)
      else $error("written word not on the output");
   a_readback_edge: assert property (
      ($changed(serial_out) && !frame_n) |-> age_reg <= 4'h8)
      else $error("serial out moved away from a rising clock");
   a_oe_frame: assert property (!frame_n [*6] |-> !serial_out_oe_n)
      else $error("serial out not driven in frame");
endmodule

bind dslc_top dslc_monitor mon_u (.ref_clk(ref_clk), .rst(rst),
   .sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
   .load_output_n(load_output_n), .clear_code_n(clear_code_n),
   .reset_n(reset_n), .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n), .dac_code(dac_code),
   .dac_update(dac_update), .twos_comp(twos_comp));

`default_nettype wire

// ===== dslc_pkg.sv
`default_nettype none

package dslc_pkg;

   // Serial frame and converter widths.
   localparam int WORD_BITS = 24;
   localparam int DAC_BITS = 16;
   localparam int DATA_BITS = 20;
   localparam int ADDR_BITS = 3;
   localparam int CNT_BITS = 5;

   // Frame buffer between the link and the register update logic.
   localparam int FIFO_WIDTH = 24;
   localparam int FIFO_DEPTH = 32;

   // Pin sampling: index of each pin in the sampled vector.
   localparam int PIN_COUNT = 6;
   localparam int PIN_SCLK = 0;
   localparam int PIN_FRAME = 1;
   localparam int PIN_SDATA = 2;
   localparam int PIN_LOAD = 3;
   localparam int PIN_CLEAR = 4;
   localparam int PIN_RESET = 5;
   // Clock and load start low, so neither edge detector sees a false
   // falling edge when the pins already sit at their idle levels.
   localparam logic [PIN_COUNT-1:0] PIN_RST_VAL = 6'h32;

   // Word addresses carried in the command field.
   localparam logic [ADDR_BITS-1:0] ADDR_DAC = 3'h1;
   localparam logic [ADDR_BITS-1:0] ADDR_CTRL = 3'h2;
   localparam logic [ADDR_BITS-1:0] ADDR_CLEAR = 3'h3;

   // Control word fields and values after reset.
   localparam int CTRL_BITS = 2;
   localparam int CTRL_TWOS_POS = 1;
   localparam logic [CTRL_BITS-1:0] CTRL_RST = 2'h0;
   localparam logic [DAC_BITS-1:0] DAC_RST = 16'h0000;
   localparam logic [DAC_BITS-1:0] CLEAR_RST = 16'h0000;
   localparam logic [DAC_BITS-1:0] SIGN_FLIP = 16'h8000;

   // Full frame length in bits and the saturation value of the counter.
   localparam logic [CNT_BITS-1:0] FRAME_LEN = 5'h18;
   localparam logic [CNT_BITS-1:0] CNT_SAT = 5'h19;

   typedef struct packed {
      logic rd;
      logic [ADDR_BITS-1:0] addr;
      logic [DATA_BITS-1:0] data;
   } dslc_word_t;

   // Members run from the top bit down, so sclk sits at bit PIN_SCLK.
   typedef struct packed {
      logic reset_n;
      logic clear_n;
      logic load_n;
      logic sdata;
      logic frame_n;
      logic sclk;
   } dslc_pins_t;

endpackage

`default_nettype wire

// ===== dslc_test.sv
`default_nettype none

module dslc_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic load_output_n = 1'b0;
   logic clear_code_n = 1'b1;
   logic reset_n = 1'b1;
   logic sclk, frame_n, serial_in, serial_out, serial_out_oe_n;
   logic dac_update, twos_comp, link_ready, frame_dropped;
   logic drop_seen = 1'b0;
   logic [15:0] dac_code;
   logic [23:0] rd;
   int fails = 0;
   int checks = 0;

   dslc_top dut_u (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
      .frame_n(frame_n), .serial_in(serial_in),
      .load_output_n(load_output_n), .clear_code_n(clear_code_n),
      .reset_n(reset_n), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .dac_code(dac_code),
      .dac_update(dac_update), .twos_comp(twos_comp),
      .link_ready(link_ready), .frame_dropped(frame_dropped));
   dslc_host_model host_u (.sclk(sclk), .frame_n(frame_n),
      .serial_in(serial_in), .serial_out(serial_out));

   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (frame_dropped === 1'b1) drop_seen <= 1'b1;

   task complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input string what, input logic [23:0] seen,
            input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task wait_upd;
      int i;
      for (i = 0; i < 400 && dac_update !== 1'b1; i++) cyc(1);
      if (i == 400) begin
         fails++;
         $display("ERROR dac_update expected 1 seen 0");
         complete_run;
      end
      cyc(1);
   endtask

   task wr(input logic [2:0] a, input logic [19:0] d);
      host_u.send({1'b0, a, d}, rd);
   endtask

   task t_write_coding;
      wr(dslc_pkg::ADDR_DAC, 20'h0A5C3);
      wait_upd;
      chk("dac_code", 24'(dac_code), 24'h00A5C3);
      wr(dslc_pkg::ADDR_CTRL, 20'h00002);
      cyc(20);
      chk("twos_comp", 24'(twos_comp), 24'h000001);
      chk("dac_code", 24'(dac_code), 24'h0025C3);
      $display("write and coding test done");
   endtask

   task t_load_high;
      load_output_n <= 1'b1;
      cyc(10);
      wr(dslc_pkg::ADDR_DAC, 20'h01234);
      cyc(40);
      chk("dac_code", 24'(dac_code), 24'h0025C3);
      load_output_n <= 1'b0;
      wait_upd;
      chk("dac_code", 24'(dac_code), 24'h009234);
      $display("load test done");
   endtask

   task t_readback;
      host_u.send({1'b1, dslc_pkg::ADDR_DAC, 20'h00000}, rd);
      host_u.send({1'b1, dslc_pkg::ADDR_CTRL, 20'h00000}, rd);
      chk("readback", rd, 24'h901234);
      host_u.send(24'h000000, rd);
      chk("readback", rd, 24'hA00002);
      $display("readback test done");
   endtask

   // Clear low stops the drain, so the buffer fills up to its refusal.
   task t_clear_fill;
      wr(dslc_pkg::ADDR_CLEAR, 20'h00F0F);
      cyc(20);
      clear_code_n <= 1'b0;
      wait_upd;
      cyc(2);
      chk("dac_code", 24'(dac_code), 24'h008F0F);
      for (int i = 0; i < 33; i++) begin
         wr(dslc_pkg::ADDR_DAC, 20'(i));
         if (i == 31) begin
            cyc(10);
            chk("link_ready", 24'(link_ready), 24'h000000);
         end
      end
      cyc(10);
      chk("frame_dropped", 24'(drop_seen), 24'h000001);
      clear_code_n <= 1'b1;
      cyc(200);
      chk("link_ready", 24'(link_ready), 24'h000001);
      chk("dac_code", 24'(dac_code), 24'h00801F);
      host_u.send({1'b1, dslc_pkg::ADDR_CLEAR, 20'h00000}, rd);
      host_u.send(24'h000000, rd);
      chk("readback", rd, 24'hB00F0F);
      $display("clear and buffer test done");
   endtask

   task t_reset_pin;
      reset_n <= 1'b0;
      cyc(12);
      chk("dac_code", 24'(dac_code), 24'h000000);
      chk("twos_comp", 24'(twos_comp), 24'h000000);
      chk("link_ready", 24'(link_ready), 24'h000001);
      reset_n <= 1'b1;
      cyc(8);
      $display("reset pin test done");
   endtask

   initial begin
      cyc(6);
      rst <= 1'b0;
      cyc(8);
      t_write_coding;
      t_load_high;
      t_readback;
      t_clear_fill;
      t_reset_pin;
      complete_run;
   end
endmodule

`default_nettype wire

// ===== dslc_top.sv
// How it works
// - Reset pin low returns every register and buffer except the pin sampling and edge registers to its power-on state.
// - Clear pin low loads the clear code into the DAC register at once.
// - Output code follows the chosen coding, binary or twos complement.
// - With load held low, the written value reaches the output at frame end.
// - Load high holds writes in the input register until load falls.
// - Readback bits change on serial_out at each rising serial clock edge.
// - Incoming serial data fills a shift register exactly 24 bits wide.
// - Each serial input bit is sampled on the serial clock falling edge.
// - Frame select low lets following falling edges shift in bits.
`default_nettype none

module dslc_sync_filter #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] agree;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit only moves once two settled samples match, which rejects glitches.
   assign agree = ~(s2_reg ^ s3_reg);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_reg <= RST_VAL;
      end else begin
         level_reg <= (s2_reg & agree) | (level_reg & ~agree);
      end
   end

   assign level = level_reg;
endmodule

module dslc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

module dslc_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic frame_n,
   input wire logic serial_in,
   input wire logic load_output_n,
   input wire logic clear_code_n,
   input wire logic reset_n,
   output logic serial_out,
   output logic serial_out_oe_n,
   output logic [dslc_pkg::DAC_BITS-1:0] dac_code,
   output logic dac_update,
   output logic twos_comp,
   output logic link_ready,
   output logic frame_dropped
);
   dslc_pkg::dslc_pins_t pins;
   logic sclk_d_reg;
   logic frame_d_reg;
   logic load_d_reg;
   logic soft_rst;
   logic sclk_fall;
   logic sclk_rise;
   logic frame_rise;
   logic load_fall;
   logic [dslc_pkg::WORD_BITS-1:0] shift_reg;
   logic [dslc_pkg::CNT_BITS-1:0] bit_cnt_reg;
   logic frame_done;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [dslc_pkg::FIFO_WIDTH-1:0] fifo_out;
   dslc_pkg::dslc_word_t head;
   logic [dslc_pkg::DAC_BITS-1:0] input_reg;
   logic [dslc_pkg::DAC_BITS-1:0] dac_reg;
   logic [dslc_pkg::DAC_BITS-1:0] clear_reg;
   logic [dslc_pkg::CTRL_BITS-1:0] ctrl_reg;
   logic [dslc_pkg::DATA_BITS-1:0] rb_value;
   logic [dslc_pkg::WORD_BITS-1:0] rb_shift_reg;
   logic serial_out_reg;
   logic update_reg;
   logic dropped_reg;
   logic write_dac;

   dslc_sync_filter #(
      .WIDTH(dslc_pkg::PIN_COUNT),
      .RST_VAL(dslc_pkg::PIN_RST_VAL)
   ) u_pins (
      .clk(ref_clk),
      .rst(rst),
      .din({reset_n, clear_code_n, load_output_n, serial_in, frame_n, sclk}),
      .level(pins)
   );

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclk_d_reg <= dslc_pkg::PIN_RST_VAL[dslc_pkg::PIN_SCLK];
         frame_d_reg <= dslc_pkg::PIN_RST_VAL[dslc_pkg::PIN_FRAME];
         load_d_reg <= dslc_pkg::PIN_RST_VAL[dslc_pkg::PIN_LOAD];
      end else begin
         sclk_d_reg <= pins.sclk;
         frame_d_reg <= pins.frame_n;
         load_d_reg <= pins.load_n;
      end
   end

   assign soft_rst = !pins.reset_n;
   assign sclk_fall = sclk_d_reg && !pins.sclk;
   assign sclk_rise = !sclk_d_reg && pins.sclk;
   assign frame_rise = !frame_d_reg && pins.frame_n;
   assign load_fall = load_d_reg && !pins.load_n;

   // Bits land only while the frame is low; the counter saturates so an
   // overlong frame is told apart from a full one and then discarded.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shift_reg <= '0;
         bit_cnt_reg <= '0;
      end else if (soft_rst) begin
         shift_reg <= '0;
         bit_cnt_reg <= '0;
      end else if (pins.frame_n) begin
         bit_cnt_reg <= '0;
      end else if (sclk_fall) begin
         shift_reg <= {shift_reg[dslc_pkg::WORD_BITS-2:0],
                       pins.sdata};
         if (bit_cnt_reg != dslc_pkg::CNT_SAT) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
         end
      end
   end

   assign frame_done = frame_rise && (bit_cnt_reg == dslc_pkg::FRAME_LEN);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dropped_reg <= 1'b0;
      end else begin
         dropped_reg <= frame_done && !fifo_in_ready && !soft_rst;
      end
   end

   // The register side stalls while clear is held, so words wait here.
   assign fifo_pop = fifo_out_valid && pins.clear_n;

   dslc_fifo #(
      .WIDTH(dslc_pkg::FIFO_WIDTH),
      .DEPTH(dslc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst(rst),
      .flush(soft_rst),
      .in_valid(frame_done),
      .in_ready(fifo_in_ready),
      .in_data(shift_reg),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   assign head = fifo_out;
   assign write_dac = fifo_pop && !head.rd &&
                      (head.addr == dslc_pkg::ADDR_DAC);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= dslc_pkg::CTRL_RST;
         clear_reg <= dslc_pkg::CLEAR_RST;
         input_reg <= dslc_pkg::DAC_RST;
      end else if (soft_rst) begin
         ctrl_reg <= dslc_pkg::CTRL_RST;
         clear_reg <= dslc_pkg::CLEAR_RST;
         input_reg <= dslc_pkg::DAC_RST;
      end else if (fifo_pop && !head.rd) begin
         unique case (head.addr)
            dslc_pkg::ADDR_DAC: begin
               input_reg <= head.data[dslc_pkg::DAC_BITS-1:0];
            end
            dslc_pkg::ADDR_CTRL: begin
               ctrl_reg <= head.data[dslc_pkg::CTRL_BITS-1:0];
            end
            dslc_pkg::ADDR_CLEAR: begin
               clear_reg <= head.data[dslc_pkg::DAC_BITS-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Clear outranks a load edge, which outranks a fresh word.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dac_reg <= dslc_pkg::DAC_RST;
         update_reg <= 1'b0;
      end else if (soft_rst) begin
         dac_reg <= dslc_pkg::DAC_RST;
         update_reg <= 1'b0;
      end else if (!pins.clear_n) begin
         dac_reg <= clear_reg;
         update_reg <= 1'b1;
      end else if (load_fall) begin
         dac_reg <= write_dac ? head.data[dslc_pkg::DAC_BITS-1:0] :
                    input_reg;
         update_reg <= 1'b1;
      end else if (write_dac && !pins.load_n) begin
         dac_reg <= head.data[dslc_pkg::DAC_BITS-1:0];
         update_reg <= 1'b1;
      end else begin
         update_reg <= 1'b0;
      end
   end

   always_comb begin
      rb_value = '0;
      unique case (head.addr)
         dslc_pkg::ADDR_DAC: begin
            rb_value[dslc_pkg::DAC_BITS-1:0] = dac_reg;
         end
         dslc_pkg::ADDR_CTRL: begin
            rb_value[dslc_pkg::CTRL_BITS-1:0] = ctrl_reg;
         end
         dslc_pkg::ADDR_CLEAR: begin
            rb_value[dslc_pkg::DAC_BITS-1:0] = clear_reg;
         end
         default: begin
         end
      endcase
   end

   // A read word arms the answer for the next frame; the host need not slow
   // the clock, as the several cycles of pin path delay end before the falling edge.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rb_shift_reg <= '0;
         serial_out_reg <= 1'b0;
      end else if (soft_rst) begin
         rb_shift_reg <= '0;
         serial_out_reg <= 1'b0;
      end else if (fifo_pop && head.rd) begin
         rb_shift_reg <= {head.rd, head.addr, rb_value};
      end else if (!pins.frame_n && sclk_rise) begin
         serial_out_reg <= rb_shift_reg[dslc_pkg::WORD_BITS-1];
         rb_shift_reg <= {rb_shift_reg[dslc_pkg::WORD_BITS-2:0], 1'b0};
      end else if (frame_rise) begin
         serial_out_reg <= 1'b0;
      end
   end

   assign twos_comp = ctrl_reg[dslc_pkg::CTRL_TWOS_POS];
   assign dac_code = twos_comp ? (dac_reg ^ dslc_pkg::SIGN_FLIP) :
                     dac_reg;
   assign dac_update = update_reg;
   assign serial_out = serial_out_reg;
   assign serial_out_oe_n = pins.frame_n;
   assign link_ready = fifo_in_ready;
   assign frame_dropped = dropped_reg;
endmodule

`default_nettype wire
